// file: bench/rcdm_chk.sv
/* Checker for rcdm_top: bus handshake, read data and output timing.
   Assumes the bench carrier is ten clk_sys samples per period. */
`timescale 1ns/1ps
`default_nettype none
module rcdm_chk (
    // Clock and reset
    input wire logic        clk_sys,
    input wire logic        rst_b,
    // Register bus
    input wire logic        wb_cyc_i,
    input wire logic        wb_stb_i,
    input wire logic        wb_we_i,
    input wire logic [11:0] wb_adr_i,
    input wire logic [3:0]  wb_sel_i,
    input wire logic [31:0] wb_dat_i,
    input wire logic [31:0] wb_dat_o,
    input wire logic        wb_ack_o,
    // Carrier and results
    input wire logic [3:0]  ref_carrier,
    input wire logic [3:0]  demod_pulse,
    input wire logic [3:0]  polarity_out
);
    logic [7:0] c1_q;
    logic [7:0] c3_q;
    logic       wr;
    default clocking cb @(posedge clk_sys); endclocking
    default disable iff (!rst_b);
    // Shadow of two control bytes, taken at the request edge
    assign wr = wb_cyc_i && wb_stb_i && wb_we_i && !wb_ack_o && wb_sel_i[0];
    always_ff @(posedge clk_sys or negedge rst_b) begin
        if (!rst_b) begin
            c1_q <= 8'h00;
            c3_q <= 8'h00;
        end else if (wr && wb_adr_i[11:2] == rcdm_pkg::IDX_CTRL_REF_A) begin
            c1_q <= wb_dat_i[7:0];
        end else if (wr && wb_adr_i[11:2] == rcdm_pkg::IDX_CTRL_REF_B) begin
            c3_q <= wb_dat_i[7:0];
        end
    end
    // Request waiting for its answer
    sequence s_req;
        wb_cyc_i && wb_stb_i && !wb_ack_o;
    endsequence
    // One carrier period high, then low
    sequence s_hi10;
        demod_pulse[0] [*8] ##1 demod_pulse[0] [*2] ##1 !demod_pulse[0];
    endsequence
    ack_answer_a: assert property (s_req |=> wb_ack_o) else $error("no ack after request");
    ack_pulse_a: assert property (wb_ack_o |=> !wb_ack_o) else $error("ack longer than one cycle");
    idle_data_a: assert property (!wb_ack_o |-> wb_dat_o == 32'h0) else $error("read data outside ack");
    read_upper_a: assert property (wb_ack_o |-> wb_dat_o[31:8] == 24'h0) else $error("upper read bits set");
    ctrl_read_a: assert property (wb_ack_o && !wb_we_i && wb_adr_i[11:2] == rcdm_pkg::IDX_CTRL_REF_A
        |-> wb_dat_o[7:0] == c1_q) else $error("control readback wrong");
    pulse_width_a: assert property ($rose(demod_pulse[0]) |-> s_hi10) else $error("pulse width wrong");
    pol_event_a: assert property ($rose(polarity_out[2]) |-> ##[0:40] $rose(demod_pulse[2]))
        else $error("polarity change without event");
    off_quiet_a: assert property ((!c1_q[3] && !$past(c1_q[3], 4)) |-> demod_pulse[0] == 1'b0)
        else $error("pulse while disabled");
    auto_off_a: assert property ((!c3_q[7] && !$past(c3_q[7], 4)) |-> polarity_out[2] == 1'b0)
        else $error("polarity while detection off");
endmodule // rcdm_chk
`default_nettype wire

// file: bench/rcdm_far_mod.sv
/* Far-end modulator: free carrier of ten clk_sys samples per period
   with duty-cycle events; assumes the 125 MHz bench clock. */
`timescale 1ns/1ps
`default_nettype none
module rcdm_far_mod #(
    parameter int GAP = 10
) (
    // Clock and reset
    input  wire logic clk_sys,
    input  wire logic rst_b,
    // Event control
    input  wire logic run,
    input  wire logic alt,
    input  wire logic pair,
    // Line side
    output logic      carrier,
    output logic      ev_mark
);
    localparam logic [4:0] LAST = 5'(GAP - 1);
    logic [3:0] ph_q;
    logic [4:0] per_q;
    logic       run_q;
    logic [3:0] hi;
    // Phase counters; run is taken once per group so no event is cut short
    always_ff @(posedge clk_sys or negedge rst_b) begin
        if (!rst_b) begin
            ph_q <= 4'h0;
            per_q <= 5'h00;
            run_q <= 1'b0;
            ev_mark <= 1'b0;
        end else begin
            ph_q <= (ph_q == 4'h9) ? 4'h0 : ph_q + 4'h1;
            if (ph_q == 4'h9) begin
                per_q <= (per_q == LAST) ? 5'h00 : per_q + 5'h01;
            end
            if (ph_q == 4'h9 && per_q == LAST) begin
                run_q <= run;
            end
            ev_mark <= ph_q == 4'h9 && per_q == LAST && run;
        end
    end
    // Wide then narrow is normal, reversed for alternate
    always_comb begin
        hi = 4'h5;
        if (run_q && per_q == 5'h00) begin
            hi = alt ? 4'h3 : 4'h7;
        end
        if (run_q && pair && per_q == 5'h01) begin
            hi = alt ? 4'h7 : 4'h3;
        end
    end
    // Events GAP carrier periods apart
    assign carrier = ph_q < hi;
endmodule // rcdm_far_mod
`default_nettype wire

// file: bench/rcdm_top_tb.sv
/* Testbench for rcdm_top: register rows, reset and demodulation cases.
   All four carriers come from one far-end model. */
`timescale 1ns/1ps
`default_nettype none
`define CHK(a, e) begin check_count++; if ((a) !== (e)) begin n_mismatch++; \
    $display("CHECK FAILED %0t got %h exp %h", $time, (a), (e)); end end
module rcdm_top_tb;
    typedef struct packed {logic [9:0] idx; logic [7:0] wd; logic [7:0] ex;} rcdm_row_s;
    logic        clk_sys, rst_b, wb_cyc_i, wb_stb_i, wb_we_i, wb_ack_o;
    logic [11:0] wb_adr_i;
    logic [3:0]  wb_sel_i, demod_pulse, polarity_out, prev;
    logic [31:0] wb_dat_i, wb_dat_o;
    logic        car, run, alt, pair, ev_mark;
    logic [7:0]  rd;
    int          n_mismatch, check_count, n_ev;
    int          n_pulse [4];
    time         t_rise [4];
    // Unmapped index 0x304 reads zero
    rcdm_row_s   rows [7] = '{'{10'h302, 8'hA5, 8'hA5}, '{10'h303, 8'h5A, 8'h5A}, '{10'h306, 8'hFF, 8'hFF},
        '{10'h307, 8'h3C, 8'h3C}, '{10'h301, 8'h01, 8'h01}, '{10'h305, 8'h01, 8'h01}, '{10'h304, 8'hFF, 8'h00}};
    rcdm_top DUT (.clk_sys(clk_sys), .rst_b(rst_b), .wb_cyc_i(wb_cyc_i), .wb_stb_i(wb_stb_i), .wb_we_i(wb_we_i),
        .wb_adr_i(wb_adr_i), .wb_sel_i(wb_sel_i), .wb_dat_i(wb_dat_i), .wb_dat_o(wb_dat_o), .wb_ack_o(wb_ack_o),
        .ref_carrier({4{car}}), .demod_pulse(demod_pulse), .polarity_out(polarity_out));
    rcdm_far_mod u_far (.clk_sys(clk_sys), .rst_b(rst_b), .run(run), .alt(alt), .pair(pair), .carrier(car),
        .ev_mark(ev_mark));
    initial begin
        clk_sys = 1'b0;
        forever #4 clk_sys = ~clk_sys;
    end
    // Count and time-stamp rising edges of each output
    always @(posedge clk_sys) begin
        for (int i = 0; i < 4; i++) begin
            if (demod_pulse[i] === 1'b1 && prev[i] === 1'b0) begin
                n_pulse[i]++;
                t_rise[i] = $time;
            end
        end
        prev <= demod_pulse;
    end
    task automatic wb_xfer(input logic we, input logic [9:0] idx, input logic [7:0] wd);
        int n;
        @(posedge clk_sys);
        wb_cyc_i <= 1'b1;
        wb_stb_i <= 1'b1;
        wb_we_i <= we;
        wb_adr_i <= {idx, 2'b00};
        wb_sel_i <= 4'h1;
        wb_dat_i <= {24'h0, wd};
        n = 0;
        do begin
            @(posedge clk_sys);
            n++;
        end while (wb_ack_o !== 1'b1 && n < 50);
        if (n >= 50) n_mismatch++;
        rd = wb_dat_o[7:0];
        wb_cyc_i <= 1'b0;
        wb_stb_i <= 1'b0;
    endtask
    // Send n events, then leave 400 cycles for the pulses to land
    task automatic send(input int n, input logic a, input logic p);
        foreach (n_pulse[i]) n_pulse[i] = 0;
        @(posedge clk_sys);
        alt <= a;
        pair <= p;
        run <= 1'b1;
        n_ev = 0;
        while (n_ev < n) begin
            @(posedge clk_sys);
            if (ev_mark === 1'b1) n_ev++;
        end
        run <= 1'b0;
        repeat (400) @(posedge clk_sys);
    endtask
    task automatic end_of_test;
        $display("checks %0d mismatches %0d", check_count, n_mismatch);
        if (n_mismatch == 0 && check_count > 0)
            $display("verification passed");
        else
            $display("verification failed");
        $finish;
    endtask
    // Watchdog: the run needs about 4000 cycles
    initial begin
        repeat (30000) @(posedge clk_sys);
        n_mismatch++;
        end_of_test();
    end
    initial begin
        {rst_b, wb_cyc_i, wb_stb_i, wb_we_i, run, alt, pair, prev} = '0;
        {wb_adr_i, wb_sel_i, wb_dat_i, n_mismatch, check_count} = '0;
        repeat (10) @(posedge clk_sys);
        rst_b <= 1'b1;
        foreach (rows[i]) begin
            wb_xfer(1'b1, rows[i].idx, rows[i].wd);
            wb_xfer(1'b0, rows[i].idx, 8'h00);
            `CHK(rd, rows[i].ex)
        end
        $display("test rows done");
        rst_b <= 1'b0;
        repeat (3) @(posedge clk_sys);
        rst_b <= 1'b1;
        foreach (rows[i]) begin
            wb_xfer(1'b0, rows[i].idx, 8'h00);
            `CHK(rd, 8'h00)
        end
        $display("test reset done");
        wb_xfer(1'b1, rcdm_pkg::IDX_CTRL_REF_A, 8'h18);
        wb_xfer(1'b1, rcdm_pkg::IDX_CTRL_REF_A2, 8'h0D); // Sync edge 0 taken as 1, sensitivity 1
        wb_xfer(1'b1, rcdm_pkg::IDX_CTRL_REF_B, 8'hB8);
        wb_xfer(1'b1, rcdm_pkg::IDX_CTRL_REF_B2, 8'h2B); // Sync edge 2, sensitivity 3
        send(4, 1'b0, 1'b0);
        `CHK({n_pulse[3], n_pulse[2], n_pulse[1], n_pulse[0]}, {32'd0, 32'd4, 32'd0, 32'd4})
        `CHK(t_rise[2] - t_rise[0], 64'd160)
        `CHK(polarity_out, 4'b0000)
        $display("test normal done");
        send(3, 1'b1, 1'b0);
        `CHK({n_pulse[3], n_pulse[2], n_pulse[1], n_pulse[0]}, {32'd0, 32'd3, 32'd3, 32'd0})
        `CHK(polarity_out, 4'b0100)
        wb_xfer(1'b0, rcdm_pkg::IDX_STATUS, 8'h00);
        `CHK(rd, 8'h04)
        $display("test alternate done");
        wb_xfer(1'b1, rcdm_pkg::IDX_BAND_PAIR_B, 8'h01); // 12.5 MHz carrier fits either band
        send(2, 1'b0, 1'b1);
        `CHK({n_pulse[3], n_pulse[2], n_pulse[1], n_pulse[0]}, {32'd2, 32'd2, 32'd2, 32'd2})
        `CHK(polarity_out, 4'b0000)
        `CHK(t_rise[1] - t_rise[0], 64'd80)
        `CHK(t_rise[3] - t_rise[0], 64'd80)
        $display("test band done");
        wb_xfer(1'b1, rcdm_pkg::IDX_CTRL_REF_A, 8'h00);
        wb_xfer(1'b1, rcdm_pkg::IDX_CTRL_REF_A, 8'h58);
        send(3, 1'b0, 1'b0);
        `CHK(n_pulse[0], 3)
        wb_xfer(1'b1, rcdm_pkg::IDX_CTRL_REF_A, 8'h00);
        wb_xfer(1'b1, rcdm_pkg::IDX_CTRL_REF_A, 8'h58);
        send(7, 1'b0, 1'b0); // 800 ns modulation period, far inside the persistence range
        `CHK(n_pulse[0] >= 10, 1'b1)
        wb_xfer(1'b0, rcdm_pkg::IDX_STATUS, 8'h00);
        `CHK(rd[4], 1'b1)
        $display("test persist done");
        end_of_test();
    end
endmodule // rcdm_top_tb
bind rcdm_top rcdm_chk u_chk (.clk_sys(clk_sys), .rst_b(rst_b), .wb_cyc_i(wb_cyc_i), .wb_stb_i(wb_stb_i),
    .wb_we_i(wb_we_i), .wb_adr_i(wb_adr_i), .wb_sel_i(wb_sel_i), .wb_dat_i(wb_dat_i), .wb_dat_o(wb_dat_o),
    .wb_ack_o(wb_ack_o), .ref_carrier(ref_carrier), .demod_pulse(demod_pulse), .polarity_out(polarity_out));
`default_nettype wire

// file: hdl/rcdm_top.sv
/*
 * Reference clock demodulator control: four demodulators that find
 * duty-cycle modulation events on their carrier inputs, plus a classic
 * Wishbone register slave. Carrier pins are asynchronous to clk_sys and
 * are resynchronised; the carrier must be slow enough that clk_sys sees
 * each high and low phase (several samples per carrier period).
 */
`timescale 1ns/1ps
`default_nettype none

module rcdm_chan (
    // Clock and reset
    input  wire logic               clk_sys,
    input  wire logic               rst_b,
    // Carrier pin and settings
    input  wire logic               carrier_pin,
    input  wire rcdm_pkg::rcdm_ctrl_s ctrl,
    input  wire logic               band,
    // Results
    output logic                    demod_pulse,
    output rcdm_pkg::rcdm_stat_s    stat
);

    // Each carrier rise closes one measured cycle: high time against period
    // tells wide from narrow. Plain sample counts keep this small, at the
    // price of needing several clk_sys samples per carrier cycle.

    logic                           sync1_q;
    logic                           sync2_q;
    logic                           prev_q;
    logic                           rise;
    logic                           fall;
    logic [rcdm_pkg::MEAS_W-1:0]    phase_cnt_q;
    logic [rcdm_pkg::MEAS_W-1:0]    high_q;
    logic                           meas_ok_q;
    logic                           blank_q;
    logic signed [rcdm_pkg::MEAS_W+1:0] diff;
    logic [3:0]                     thr;
    logic                           wide;
    logic                           narrow;
    logic                           hit;
    logic                           real_evt;
    logic                           synth_evt;
    logic                           evt;
    logic [rcdm_pkg::GAP_W-1:0]     gap_q;
    logic [rcdm_pkg::GAP_W-1:0]     gap_next;
    logic [rcdm_pkg::GAP_W-1:0]     learned_q;
    logic [2:0]                     consec_q;
    logic                           armed_q;
    logic [1:0]                     dly_q;
    logic                           pulse_q;
    logic                           pol_q;

    // Two-flop resynchroniser, then an edge history flop
    // Only sync2_q feeds logic; sync1_q may still be settling
    always_ff @(posedge clk_sys or negedge rst_b) begin
        if (!rst_b) begin
            sync1_q <= 1'b0;
            sync2_q <= 1'b0;
            prev_q  <= 1'b0;
        end else begin
            sync1_q <= carrier_pin;
            sync2_q <= sync1_q;
            prev_q  <= sync2_q;
        end
    end

    assign rise = sync2_q & ~prev_q;
    assign fall = ~sync2_q & prev_q;

    // High time and period of the carrier, in clk_sys samples
    // Counter saturates, so a stalled carrier never wraps into a short period
    always_ff @(posedge clk_sys or negedge rst_b) begin
        if (!rst_b) begin
            phase_cnt_q <= '0;
            high_q      <= '0;
            meas_ok_q   <= 1'b0;
        end else if (!ctrl.enable) begin // Channel off clears all
            phase_cnt_q <= '0;
            high_q      <= '0;
            meas_ok_q   <= 1'b0;
        end else begin
            if (rise) begin
                phase_cnt_q <= rcdm_pkg::MEAS_W'(1);
                meas_ok_q   <= 1'b1; // First period after enable is partial
            end else if (phase_cnt_q != '1) begin
                phase_cnt_q <= phase_cnt_q + rcdm_pkg::MEAS_W'(1);
            end
            if (fall) begin
                high_q <= phase_cnt_q;
            end
        end
    end

    // Duty imbalance against a threshold set by sensitivity and band
    // A faster carrier gives fewer samples per cycle, so the same duty
    // step spans fewer counts; the upper band halves the threshold
    always_comb begin
        case (ctrl.sens)
            2'd0:    thr = rcdm_pkg::THR_SENS0;
            2'd1:    thr = rcdm_pkg::THR_SENS1;
            2'd2:    thr = rcdm_pkg::THR_SENS2;
            default: thr = rcdm_pkg::THR_SENS3;
        endcase
        thr = thr >> band; // Upper band has fewer samples per period
    end

    // Two spare bits keep the signed difference from overflowing
    assign diff   = $signed({1'b0, high_q, 1'b0}) - $signed({2'b00, phase_cnt_q});
    assign wide   = diff > $signed({6'd0, thr});  // Above half duty
    assign narrow = -diff > $signed({6'd0, thr}); // Below half duty

    // Which imbalance counts as an event start
    // Auto detection takes either order, which costs some sensitivity:
    // a lone narrow cycle from a noisy carrier also qualifies
    always_comb begin
        if (ctrl.auto_pol) begin
            hit = wide | narrow; // Expected polarity ignored here
        end else if (ctrl.exp_pol) begin
            hit = narrow;        // Alternate: narrow pulse first
        end else begin
            hit = wide;          // Normal: wide pulse first
        end
    end

    // Evaluate the finished carrier cycle on each rising edge
    // Synthetic events keep the learned spacing once enough real ones matched
    assign real_evt  = ctrl.enable & rise & meas_ok_q & ~blank_q & hit;
    assign gap_next  = (gap_q == '1) ? gap_q : gap_q + rcdm_pkg::GAP_W'(1);
    assign synth_evt = ctrl.enable & rise & ~real_evt & ctrl.persist
                       & (consec_q >= rcdm_pkg::PERSIST_MIN_EVT) & (gap_next == learned_q);
    assign evt       = real_evt | synth_evt;

    // The optional second, complementary pulse is not a new event
    always_ff @(posedge clk_sys or negedge rst_b) begin
        if (!rst_b) begin
            blank_q <= 1'b0;
        end else if (!ctrl.enable) begin
            blank_q <= 1'b0;
        end else if (rise) begin
            blank_q <= real_evt;
        end
    end

    // Modulation period learning and consecutive event count
    // A mismatched period restarts the count at one, so one stray or mistimed
    // event costs several periods before persistence is trusted again
    always_ff @(posedge clk_sys or negedge rst_b) begin
        if (!rst_b) begin
            gap_q     <= '0;
            learned_q <= '0;
            consec_q  <= '0;
        end else if (!ctrl.enable) begin
            gap_q     <= '0;
            learned_q <= '0;
            consec_q  <= '0;
        end else if (rise) begin
            if (evt) begin
                gap_q <= '0;
            end else begin
                gap_q <= gap_next;
            end
            if (real_evt) begin
                learned_q <= gap_next;
                if (gap_next == learned_q && consec_q != rcdm_pkg::CONSEC_MAX) begin
                    consec_q <= consec_q + 3'd1;
                end else if (gap_next != learned_q) begin
                    consec_q <= 3'd1;
                end
            end
        end
    end

    // Output pulse: one carrier period, 1..3 periods after the base edge
    // Events are at least eight periods apart, so a new event never
    // lands on a pulse that is still armed
    always_ff @(posedge clk_sys or negedge rst_b) begin
        if (!rst_b) begin
            armed_q <= 1'b0;
            dly_q   <= 2'd0;
            pulse_q <= 1'b0;
        end else if (!ctrl.enable) begin
            armed_q <= 1'b0;
            dly_q   <= 2'd0;
            pulse_q <= 1'b0;
        end else if (rise) begin
            pulse_q <= armed_q && dly_q == 2'd1;
            if (evt) begin
                armed_q <= 1'b1;
                // Sync edge 0 is not meaningful, treated as 1
                dly_q   <= (ctrl.sync_edge == 2'd0) ? 2'd1 : ctrl.sync_edge;
            end else if (armed_q) begin
                armed_q <= dly_q != 2'd1;
                dly_q   <= dly_q - 2'd1;
            end
        end
    end

    // Polarity latched per classified event, held in between
    // Forced low rather than held, so no stale polarity shows after a mode change
    always_ff @(posedge clk_sys or negedge rst_b) begin
        if (!rst_b) begin
            pol_q <= 1'b0;
        end else if (!ctrl.enable || !ctrl.auto_pol) begin
            pol_q <= 1'b0; // No indication without detection
        end else if (real_evt) begin
            pol_q <= narrow; // 0 normal, 1 alternate
        end
    end

    // Persistence is reported once the learned period is trusted
    assign demod_pulse         = pulse_q;
    assign stat.polarity       = pol_q;
    assign stat.persist_active = ctrl.persist & (consec_q >= rcdm_pkg::PERSIST_MIN_EVT);

endmodule // rcdm_chan

// Behaviour
// - Normal event: wide pulse, then optional narrow
// - Control D2 selects expected event polarity
// - Expected polarity ignored while auto detection on
// - Control D7 enables automatic polarity detection
// - Auto detection latches polarity per event
// - No polarity indication while detection off
// - Sensitivity D1:D0, zero most sensitive
// - Control D6 enables persistence
// - Persistence learns period, continues pulses after
// - Five consecutive events before persistent pulses
// - Band select D0, zero lower band
// - Each band bit covers one reference pair
// - Control D3 enables the demodulator
// - One-period pulse, 1..3 periods after base
module rcdm_top (
    // Clock and reset
    input  wire logic        clk_sys,
    input  wire logic        rst_b,
    // Wishbone classic slave
    input  wire logic        wb_cyc_i,
    input  wire logic        wb_stb_i,
    input  wire logic        wb_we_i,
    input  wire logic [11:0] wb_adr_i,
    input  wire logic [3:0]  wb_sel_i,
    input  wire logic [31:0] wb_dat_i,
    output logic      [31:0] wb_dat_o,
    output logic             wb_ack_o,
    // Carrier pins: reference_input_one .. reference_input_four
    input  wire logic [3:0]  ref_carrier,
    // Demodulated outputs
    output logic      [3:0]  demod_pulse,
    output logic      [3:0]  polarity_out
);

    // Control bytes in channel order: reference inputs one to four
    logic [7:0]              ctrl_q [rcdm_pkg::N_REF];
    logic                    band_a_q;
    logic                    band_b_q;
    logic                    ack_q;
    logic [31:0]             rdata_q;
    logic [9:0]              idx;
    logic                    req;
    logic                    wr_lane0;
    logic [31:0]             rdata_d;
    rcdm_pkg::rcdm_stat_s    stat [rcdm_pkg::N_REF];
    logic [3:0]              persist_act;

    assign idx      = wb_adr_i[11:2];
    assign req      = wb_cyc_i & wb_stb_i & ~ack_q;
    assign wr_lane0 = req & wb_we_i & wb_sel_i[0];

    // Register writes on the request cycle; only byte lane 0 carries data
    // The master holds its data until ack, so storing early is safe and
    // the stored value is the one that gets acknowledged
    always_ff @(posedge clk_sys or negedge rst_b) begin
        if (!rst_b) begin
            for (int i = 0; i < rcdm_pkg::N_REF; i++) begin
                ctrl_q[i] <= rcdm_pkg::RST_CTRL;
            end
            band_a_q <= rcdm_pkg::RST_BAND;
            band_b_q <= rcdm_pkg::RST_BAND;
        end else if (wr_lane0) begin
            case (idx)
                rcdm_pkg::IDX_CTRL_REF_A:  ctrl_q[0] <= wb_dat_i[7:0];
                rcdm_pkg::IDX_CTRL_REF_A2: ctrl_q[1] <= wb_dat_i[7:0];
                rcdm_pkg::IDX_CTRL_REF_B:  ctrl_q[2] <= wb_dat_i[7:0];
                rcdm_pkg::IDX_CTRL_REF_B2: ctrl_q[3] <= wb_dat_i[7:0];
                rcdm_pkg::IDX_BAND_PAIR_A: band_a_q  <= wb_dat_i[rcdm_pkg::BIT_BAND];
                rcdm_pkg::IDX_BAND_PAIR_B: band_b_q  <= wb_dat_i[rcdm_pkg::BIT_BAND];
                default: ;                 // Unmapped writes are dropped
            endcase
        end
    end

    // Read mux; unmapped indices read as zero
    // Status is a live snapshot; reading it clears nothing
    always_comb begin
        rdata_d = 32'h0000_0000;
        case (idx)
            rcdm_pkg::IDX_CTRL_REF_A:  rdata_d[7:0] = ctrl_q[0];
            rcdm_pkg::IDX_CTRL_REF_A2: rdata_d[7:0] = ctrl_q[1];
            rcdm_pkg::IDX_CTRL_REF_B:  rdata_d[7:0] = ctrl_q[2];
            rcdm_pkg::IDX_CTRL_REF_B2: rdata_d[7:0] = ctrl_q[3];
            rcdm_pkg::IDX_BAND_PAIR_A: rdata_d[rcdm_pkg::BIT_BAND] = band_a_q;
            rcdm_pkg::IDX_BAND_PAIR_B: rdata_d[rcdm_pkg::BIT_BAND] = band_b_q;
            rcdm_pkg::IDX_STATUS: begin
                rdata_d[rcdm_pkg::BIT_STAT_POL_LO +: 4] = polarity_out;
                rdata_d[rcdm_pkg::BIT_STAT_PER_LO +: 4] = persist_act;
            end
            default: rdata_d = 32'h0000_0000;
        endcase
    end

    // Every access is answered one cycle later, ack dropped the next
    // Registered ack costs a wait state but keeps the bus path short;
    // a strobe still high during ack is not taken a second time
    always_ff @(posedge clk_sys or negedge rst_b) begin
        if (!rst_b) begin
            ack_q   <= 1'b0;
            rdata_q <= 32'h0000_0000;
        end else begin
            ack_q   <= req;
            rdata_q <= req ? rdata_d : 32'h0000_0000;
        end
    end

    assign wb_ack_o = ack_q;
    assign wb_dat_o = rdata_q;

    // One demodulator per reference input; pairs share a band bit
    // Pair A serves inputs one and two, pair B inputs three and four
    for (genvar g = 0; g < rcdm_pkg::N_REF; g++) begin : g_chan
        rcdm_chan u_chan (
            .clk_sys     (clk_sys),
            .rst_b       (rst_b),
            .carrier_pin (ref_carrier[g]),
            .ctrl        (rcdm_pkg::rcdm_ctrl_s'(ctrl_q[g])),
            .band        ((g < 2) ? band_a_q : band_b_q),
            .demod_pulse (demod_pulse[g]),
            .stat        (stat[g])
        );
        assign polarity_out[g] = stat[g].polarity;
        assign persist_act[g]  = stat[g].persist_active;
    end

endmodule // rcdm_top

`default_nettype wire

// file: pkg/rcdm_pkg.sv
/*
 * Package for the reference clock demodulator control block: register
 * indices, control field layout, reset values and detection thresholds.
 * Assumes a 32-bit classic Wishbone register port and byte-wide registers.
 */
`default_nettype none

package rcdm_pkg;

    // Number of reference inputs and demodulators
    localparam int unsigned N_REF = 4;

    // Register indices; byte address is four times the index
    localparam logic [9:0] IDX_BAND_PAIR_A   = 10'h301;
    localparam logic [9:0] IDX_CTRL_REF_A    = 10'h302;
    localparam logic [9:0] IDX_CTRL_REF_A2   = 10'h303;
    localparam logic [9:0] IDX_BAND_PAIR_B   = 10'h305;
    localparam logic [9:0] IDX_CTRL_REF_B    = 10'h306;
    localparam logic [9:0] IDX_CTRL_REF_B2   = 10'h307;
    localparam logic [9:0] IDX_STATUS        = 10'h308;

    // Field positions within a control register; BIT_BAND is the bit within a band register
    localparam int unsigned BIT_SENS_LO      = 0;
    localparam int unsigned BIT_EXP_POL      = 2;
    localparam int unsigned BIT_ENABLE       = 3;
    localparam int unsigned BIT_SYNC_LO      = 4;
    localparam int unsigned BIT_PERSIST      = 6;
    localparam int unsigned BIT_AUTO_POL     = 7;
    localparam int unsigned BIT_BAND         = 0;

    // Status register field positions
    localparam int unsigned BIT_STAT_POL_LO  = 0;
    localparam int unsigned BIT_STAT_PER_LO  = 4;

    // Reset values
    localparam logic [7:0] RST_CTRL          = 8'h00;
    localparam logic       RST_BAND          = 1'b0;

    // Measurement widths and counts
    localparam int unsigned MEAS_W           = 8;
    localparam int unsigned GAP_W            = 16;
    localparam logic [2:0]  PERSIST_MIN_EVT  = 3'd5;
    localparam logic [2:0]  CONSEC_MAX       = 3'd7;

    // Duty imbalance threshold (2*high - period, in samples) per sensitivity
    localparam logic [3:0] THR_SENS0         = 4'h1;
    localparam logic [3:0] THR_SENS1         = 4'h2;
    localparam logic [3:0] THR_SENS2         = 4'h4;
    localparam logic [3:0] THR_SENS3         = 4'h6;

    // Control register, bit order D7..D0
    typedef struct packed {
        logic       auto_pol;
        logic       persist;
        logic [1:0] sync_edge;
        logic       enable;
        logic       exp_pol;
        logic [1:0] sens;
    } rcdm_ctrl_s;

    // Per-channel status
    typedef struct packed {
        logic polarity;
        logic persist_active;
    } rcdm_stat_s;

endpackage

`default_nettype wire
